// *** design/cmp_pkg.sv ***
// register map, field positions and state type of the dual comparator control block
package cmp_pkg;
   localparam int          AW           = 4;
   localparam logic [3:0]  CC_ADDR      = 4'h0;
   localparam logic [3:0]  RC_ADDR      = 4'h4;
   localparam logic [3:0]  IST_ADDR     = 4'h8;
   localparam logic [3:0]  IMASK_ADDR   = 4'hC;
   // comparator_control fields
   localparam int          IDLE_STOP    = 15;
   localparam int          B_FLAG       = 13;
   localparam int          A_FLAG       = 12;
   localparam int          B_EN         = 11;
   localparam int          A_EN         = 10;
   localparam int          B_PAD        = 9;
   localparam int          A_PAD        = 8;
   localparam int          B_RES        = 7;
   localparam int          A_RES        = 6;
   localparam int          B_INV        = 5;
   localparam int          A_INV        = 4;
   localparam int          B_MINUS      = 3;
   localparam int          B_PLUS       = 2;
   localparam int          A_MINUS      = 1;
   localparam int          A_PLUS       = 0;
   localparam logic [15:0] CC_WR_MASK   = 16'h8F3F;
   localparam logic [15:0] CC_FLAG_MASK = 16'h3000;
   localparam logic [15:0] CC_RESET     = 16'h0000;
   // reference_control fields
   localparam int          REF_PWR      = 7;
   localparam int          REF_PIN      = 6;
   localparam int          REF_RANGE    = 5;
   localparam int          REF_SRC      = 4;
   localparam int          LVL_HI       = 3;
   localparam logic [7:0]  RC_RESET     = 8'h00;
   localparam logic [1:0]  IRQ_RESET    = 2'h0;
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

   typedef struct packed {
      logic [15:0] cc;
      logic [7:0]  rc;
      logic [1:0]  res;
      logic [1:0]  ist;
      logic [1:0]  imask;
      logic [31:0] rdata;
      logic        err;
   } state_t;
endpackage

// *** design/dual_comparator_control.sv ***
// control, status and interrupt logic for two comparators and their reference ladder
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// What this block does, and what software must do
// R1: each comparator has an enable bit, bits 11 and 10
// R2: output-enable bits 9 and 8 let the result drive the pad
// R3: software must route an enabled comparator output to a remappable pin
// R4: result bits 7 and 6 read one when plus exceeds minus, inversion off
// R5: inversion bits 5 and 4 invert the comparator output when set
// R6: minus-select bits 3 and 1 pick plus pin when one, minus pin when zero
// R7: plus-select bits 2 and 0 pick plus pin when one, reference when zero
// R8: reference range select at bit 5 picks coarse or fine steps
// R9: four-bit reference level picks one of sixteen steps
// R10: reference source select at bit 4 picks supply rails or external pins
// R11: software waits for reference settling after changing range, source or level
// R12: change flags bits 13 and 12 set when a comparator output changes
// R13: reference power enable bit powers the ladder on or down
// R14: an enabled pad carries the same post-inversion result that software reads
module dual_comparator_control
   import cmp_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          resetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          cmp_a_raw,
   input  wire logic          cmp_b_raw,
   input  wire logic          idle,
   output logic               cmp_a_on,
   output logic               cmp_b_on,
   output logic               cmp_a_plus_sel,
   output logic               cmp_a_minus_sel,
   output logic               cmp_b_plus_sel,
   output logic               cmp_b_minus_sel,
   output logic               cmp_a_pad_out,
   output logic               cmp_a_pad_oe,
   output logic               cmp_b_pad_out,
   output logic               cmp_b_pad_oe,
   output logic               ref_power,
   output logic               ref_pin_enable,
   output logic               ref_range,
   output logic               ref_source,
   output logic      [3:0]    ref_level,
   output logic               irq
);

   state_t      q;
   state_t      d;
   logic        setup;
   logic        access;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        res_a;
   logic        res_b;
   logic [1:0]  chg;
   logic [15:0] cc_view;

   // disabled comparators read as zero so a stale analog level never leaks out
   function automatic logic cmp_result(input logic raw,
                                       input logic en,
                                       input logic inv);
      return en & (raw ^ inv);
   endfunction

   assign setup  = psel & ~penable;
   assign access = psel & penable;
   assign wr     = access & pwrite;
   assign rd     = access & ~pwrite;
   assign mapped = (paddr == CC_ADDR) | (paddr == RC_ADDR) |
                   (paddr == IST_ADDR) | (paddr == IMASK_ADDR);

   always_comb begin
      cc_view        = q.cc;
      cc_view[B_RES] = q.res[1];                                   // [R4]
      cc_view[A_RES] = q.res[0];                                   // [R4]
   end

   always_comb begin
      d     = q;
      res_a = cmp_result(cmp_a_raw, q.cc[A_EN], q.cc[A_INV]);      // [R4] [R5]
      res_b = cmp_result(cmp_b_raw, q.cc[B_EN], q.cc[B_INV]);      // [R4] [R5]
      d.res = {res_b, res_a};
      chg   = d.res ^ q.res;
      if (wr && paddr == CC_ADDR) begin
         // flags can only be cleared by writing zero, never set by software
         d.cc = (pwdata[15:0] & CC_WR_MASK) |
                (q.cc & pwdata[15:0] & CC_FLAG_MASK);              // [R1] [R2]
      end
      if (wr && paddr == RC_ADDR) begin
         d.rc = pwdata[7:0];                                       // [R8] [R9] [R10] [R13]
      end
      if (wr && paddr == IMASK_ADDR) begin
         d.imask = pwdata[1:0];
      end
      if (rd && paddr == IST_ADDR) begin
         d.ist = IRQ_RESET;
      end
      // set after clear so an event in the clearing cycle survives
      d.cc[A_FLAG] = d.cc[A_FLAG] | chg[0];                        // [R12]
      d.cc[B_FLAG] = d.cc[B_FLAG] | chg[1];                        // [R12]
      d.ist        = d.ist | chg;
      if (setup) begin
         d.err   = ~mapped;
         d.rdata = RDATA_RESET;
         unique case (paddr)
            CC_ADDR:    d.rdata[15:0] = cc_view;
            RC_ADDR:    d.rdata[7:0]  = q.rc;
            IST_ADDR:   d.rdata[1:0]  = q.ist;
            IMASK_ADDR: d.rdata[1:0]  = q.imask;
            default:    d.rdata       = RDATA_RESET;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q.cc    <= CC_RESET;
         q.rc    <= RC_RESET;
         q.res   <= IRQ_RESET;
         q.ist   <= IRQ_RESET;
         q.imask <= IRQ_RESET;
         q.rdata <= RDATA_RESET;
         q.err   <= 1'h0;
      end else begin
         q <= d;
      end
   end

   // zero wait states: every access completes at its first access edge
   assign pready  = 1'b1;
   assign pslverr = access & q.err;
   assign prdata  = q.rdata;

   assign cmp_a_on        = q.cc[A_EN];                            // [R1]
   assign cmp_b_on        = q.cc[B_EN];                            // [R1]
   assign cmp_a_plus_sel  = q.cc[A_PLUS];                          // [R7]
   assign cmp_a_minus_sel = q.cc[A_MINUS];                         // [R6]
   assign cmp_b_plus_sel  = q.cc[B_PLUS];                          // [R7]
   assign cmp_b_minus_sel = q.cc[B_MINUS];                         // [R6]
   // pad only valid once software routes it to a remappable pin
   assign cmp_a_pad_oe    = q.cc[A_PAD];                           // [R2] [R3]
   assign cmp_b_pad_oe    = q.cc[B_PAD];                           // [R2] [R3]
   assign cmp_a_pad_out   = q.res[0];                              // [R14]
   assign cmp_b_pad_out   = q.res[1];                              // [R14]
   assign ref_power       = q.rc[REF_PWR];                         // [R13]
   assign ref_pin_enable  = q.rc[REF_PIN];
   assign ref_range       = q.rc[REF_RANGE];                       // [R8]
   assign ref_source      = q.rc[REF_SRC];                         // [R10]
   assign ref_level       = q.rc[LVL_HI:0];                        // [R9]
   // no settling delay is modelled here; software owns that wait [R11]
   assign irq = (|(q.ist & q.imask)) & ~(q.cc[IDLE_STOP] & idle);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_enable_write: assert property ( // [R1]
      wr && paddr == CC_ADDR |=>
         cmp_a_on == $past(pwdata[A_EN]) && cmp_b_on == $past(pwdata[B_EN]))
      else $error("comparator enable does not follow the write");

   a_pad_enable: assert property ( // [R2]
      wr && paddr == CC_ADDR |=>
         cmp_a_pad_oe == $past(pwdata[A_PAD]) && cmp_b_pad_oe == $past(pwdata[B_PAD]))
      else $error("pad enable does not follow the write");

   a_result_plain: assert property ( // [R4]
      cmp_a_on && !q.cc[A_INV] ##1 cmp_a_on |->
         q.res[0] == $past(cmp_a_raw))
      else $error("result a differs from compare with inversion off");

   a_result_invert: assert property ( // [R5]
      cmp_b_on && q.cc[B_INV] ##1 cmp_b_on |->
         q.res[1] == !$past(cmp_b_raw))
      else $error("result b not inverted");

   a_result_read: assert property ( // [R4]
      setup && paddr == CC_ADDR |=>
         prdata[A_RES] == $past(q.res[0]) && prdata[B_RES] == $past(q.res[1]))
      else $error("result bits read back wrong");

   a_minus_select: assert property ( // [R6]
      wr && paddr == CC_ADDR |=>
         cmp_a_minus_sel == $past(pwdata[A_MINUS]) &&
         cmp_b_minus_sel == $past(pwdata[B_MINUS]))
      else $error("minus input select wrong");

   a_plus_select: assert property ( // [R7]
      wr && paddr == CC_ADDR |=>
         cmp_a_plus_sel == $past(pwdata[A_PLUS]) &&
         cmp_b_plus_sel == $past(pwdata[B_PLUS]))
      else $error("plus input select wrong");

   a_ref_range: assert property ( // [R8]
      wr && paddr == RC_ADDR |=> ref_range == $past(pwdata[REF_RANGE]))
      else $error("reference range not written");

   a_ref_level: assert property ( // [R9]
      wr && paddr == RC_ADDR |=> ref_level == $past(pwdata[LVL_HI:0]))
      else $error("reference level not written");

   a_ref_source: assert property ( // [R10]
      wr && paddr == RC_ADDR |=> ref_source == $past(pwdata[REF_SRC]))
      else $error("reference source not written");

   a_change_flag: assert property ( // [R12]
      q.res[0] != $past(q.res[0]) |-> q.cc[A_FLAG] && q.ist[0])
      else $error("change of result a did not set its flag");

   a_ref_power: assert property ( // [R13]
      wr && paddr == RC_ADDR |=> ref_power == $past(pwdata[REF_PWR]))
      else $error("reference power not written");

   a_pad_matches: assert property ( // [R14]
      setup && paddr == CC_ADDR && $stable(q.res) |=>
         prdata[B_RES] == cmp_b_pad_out || $changed(q.res))
      else $error("pad value differs from read-back result");

   a_pad_match_a: assert property ( // [R14]
      setup && paddr == CC_ADDR |=> prdata[A_RES] == $past(cmp_a_pad_out))
      else $error("pad a differs from read-back result");

   a_change_flag_b: assert property ( // [R12]
      q.res[1] != $past(q.res[1]) |-> q.cc[B_FLAG] && q.ist[1])
      else $error("change of result b did not set its flag");

   a_result_plain_b: assert property ( // [R4]
      cmp_b_on && !q.cc[B_INV] ##1 cmp_b_on |->
         q.res[1] == $past(cmp_b_raw))
      else $error("result b differs from compare with inversion off");

   a_result_invert_a: assert property ( // [R5]
      cmp_a_on && q.cc[A_INV] ##1 cmp_a_on |->
         q.res[0] == !$past(cmp_a_raw))
      else $error("result a not inverted");

   a_off_zero_a: assert property ( // [R1]
      !cmp_a_on |=> !q.res[0] && !cmp_a_pad_out)
      else $error("disabled comparator a does not read zero");

   a_off_zero_b: assert property ( // [R1]
      !cmp_b_on |=> !q.res[1] && !cmp_b_pad_out)
      else $error("disabled comparator b does not read zero");

   a_cc_hold: assert property ( // [R1]
      !(wr && paddr == CC_ADDR) |=>
         $stable({cmp_a_on, cmp_b_on, cmp_a_pad_oe, cmp_b_pad_oe, cmp_a_plus_sel,
                  cmp_a_minus_sel, cmp_b_plus_sel, cmp_b_minus_sel}))
      else $error("comparator controls changed without a write");

   a_cc_upper_zero: assert property (
      setup && paddr == CC_ADDR |=> prdata[31:16] == 16'h0000)
      else $error("unused comparator control bits read nonzero");

   // flags: sticky, cleared only by writing zero, and an event in that cycle wins
   a_flag_sticky_a: assert property ( // [R12]
      q.cc[A_FLAG] && !(wr && paddr == CC_ADDR && !pwdata[A_FLAG]) |=> q.cc[A_FLAG])
      else $error("flag a dropped without a clearing write");

   a_flag_sticky_b: assert property ( // [R12]
      q.cc[B_FLAG] && !(wr && paddr == CC_ADDR && !pwdata[B_FLAG]) |=> q.cc[B_FLAG])
      else $error("flag b dropped without a clearing write");

   a_flag_clear_a: assert property ( // [R12]
      wr && paddr == CC_ADDR && !pwdata[A_FLAG] ##1 q.res[0] == $past(q.res[0]) |->
         !q.cc[A_FLAG])
      else $error("flag a not cleared by writing zero");

   a_flag_clear_b: assert property ( // [R12]
      wr && paddr == CC_ADDR && !pwdata[B_FLAG] ##1 q.res[1] == $past(q.res[1]) |->
         !q.cc[B_FLAG])
      else $error("flag b not cleared by writing zero");

   a_flag_unset_a: assert property ( // [R12]
      wr && paddr == CC_ADDR && !q.cc[A_FLAG] ##1 q.res[0] == $past(q.res[0]) |->
         !q.cc[A_FLAG])
      else $error("software write set flag a");

   a_flag_unset_b: assert property ( // [R12]
      wr && paddr == CC_ADDR && !q.cc[B_FLAG] ##1 q.res[1] == $past(q.res[1]) |->
         !q.cc[B_FLAG])
      else $error("software write set flag b");

   a_status_clear: assert property ( // [R12]
      rd && paddr == IST_ADDR ##1 q.res == $past(q.res) |-> q.ist == IRQ_RESET)
      else $error("status read did not clear it");

   a_status_sticky_a: assert property ( // [R12]
      q.ist[0] && !(rd && paddr == IST_ADDR) |=> q.ist[0])
      else $error("status bit a dropped without a read");

   a_status_sticky_b: assert property ( // [R12]
      q.ist[1] && !(rd && paddr == IST_ADDR) |=> q.ist[1])
      else $error("status bit b dropped without a read");

   a_status_read: assert property ( // [R12]
      setup && paddr == IST_ADDR |=> prdata == 32'($past(q.ist)))
      else $error("status read back wrong");

   a_irq_raise: assert property ( // [R12]
      (q.ist & q.imask) != IRQ_RESET && !(q.cc[IDLE_STOP] && idle) |-> irq)
      else $error("unmasked status does not raise the interrupt");

   a_irq_quiet: assert property ( // [R12]
      (q.ist & q.imask) == IRQ_RESET || (q.cc[IDLE_STOP] && idle) |-> !irq)
      else $error("interrupt high with nothing unmasked pending");

   a_mask_write: assert property ( // [R12]
      wr && paddr == IMASK_ADDR |=> q.imask == $past(pwdata[1:0]))
      else $error("interrupt mask not written");

   a_mask_read: assert property ( // [R12]
      setup && paddr == IMASK_ADDR |=> prdata == 32'($past(q.imask)))
      else $error("interrupt mask read back wrong");

   a_ref_pin: assert property (
      wr && paddr == RC_ADDR |=> ref_pin_enable == $past(pwdata[REF_PIN]))
      else $error("reference pin enable not written");

   a_ref_hold: assert property ( // [R13]
      !(wr && paddr == RC_ADDR) |=>
         $stable({ref_power, ref_pin_enable, ref_range, ref_source, ref_level}))
      else $error("reference controls changed without a write");

   a_ref_read: assert property ( // [R13]
      setup && paddr == RC_ADDR |=> prdata == 32'($past(q.rc)))
      else $error("reference control read back wrong");

   // bus responses for mapped registers and for holes in the map
   a_slave_error: assert property (
      access && !mapped |-> pslverr)
      else $error("no error response for an unmapped register");

   a_mapped_ok: assert property (
      access && mapped |-> !pslverr)
      else $error("error response on a mapped register");

   a_unmapped_zero: assert property (
      setup && !mapped |=> prdata == RDATA_RESET)
      else $error("unmapped register does not read zero");

   a_unmapped_ignored: assert property (
      wr && !mapped |=> $stable({q.rc, q.imask}))
      else $error("write to an unmapped register changed state");

endmodule

// *** verification/cmp_analog_model.sv ***
// behavioural analog comparator core and reference ladder facing the control block
`timescale 1ns/1ps
module cmp_analog_model (
   input  wire logic       clk,
   input  wire logic       on,
   input  wire logic       plus_sel,
   input  wire logic       minus_sel,
   input  wire logic       ref_power,
   input  wire logic       ref_range,
   input  wire logic [3:0] ref_level,
   input  wire logic [7:0] vin_plus,
   input  wire logic [7:0] vin_minus,
   output logic            raw
);
   logic [7:0] vref;
   logic [7:0] pos;
   logic [7:0] neg;
   // fine range steps by one, coarse by two; a powered-down ladder sits at zero
   assign vref = !ref_power ? 8'h00 :
                 ref_range ? {4'h0, ref_level} : {3'h0, ref_level, 1'h0};
   assign pos = plus_sel ? vin_plus : vref;
   assign neg = minus_sel ? vin_plus : vin_minus;
   // a disabled core is not steady, so its output wanders every cycle;
   // an unknown start settles to one at the first edge
   always @(posedge clk) begin
      raw <= on ? (pos > neg) : (raw !== 1'h1);
   end
endmodule

// *** verification/test_dual_comparator_control.sv ***
// self-checking bench for the dual comparator control block over apb
`timescale 1ns/1ps
module test_dual_comparator_control;
   import cmp_pkg::*;
   logic          clk, resetn, psel, penable, pwrite, idle, pready, pslverr, irq, err;
   logic [AW-1:0] paddr;
   logic [31:0]   pwdata, prdata, q;
   logic          a_raw, b_raw, a_on, b_on, a_ps, a_ms, b_ps, b_ms;
   logic          a_out, a_oe, b_out, b_oe, r_pwr, r_pin, r_rng, r_src;
   logic [3:0]    r_lvl;
   logic [7:0]    vp, vm;
   int            error_cnt, checks_done;

   dual_comparator_control dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_a_raw(a_raw), .cmp_b_raw(b_raw), .idle(idle), .cmp_a_on(a_on),
      .cmp_b_on(b_on), .cmp_a_plus_sel(a_ps), .cmp_a_minus_sel(a_ms), .cmp_b_plus_sel(b_ps),
      .cmp_b_minus_sel(b_ms), .cmp_a_pad_out(a_out), .cmp_a_pad_oe(a_oe),
      .cmp_b_pad_out(b_out), .cmp_b_pad_oe(b_oe), .ref_power(r_pwr), .ref_pin_enable(r_pin),
      .ref_range(r_rng), .ref_source(r_src), .ref_level(r_lvl), .irq(irq));
   cmp_analog_model ma (.clk(clk), .on(a_on), .plus_sel(a_ps), .minus_sel(a_ms),
      .ref_power(r_pwr), .ref_range(r_rng), .ref_level(r_lvl), .vin_plus(vp), .vin_minus(vm),
      .raw(a_raw));
   cmp_analog_model mb (.clk(clk), .on(b_on), .plus_sel(b_ps), .minus_sel(b_ms),
      .ref_power(r_pwr), .ref_range(r_rng), .ref_level(r_lvl), .vin_plus(vp), .vin_minus(vm),
      .raw(b_raw));

   task automatic summarize();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one idle edge after each transfer keeps psel from being driven twice in a step
   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'h0, a, 32'h0);
      chk(q & m, exp);
   endtask

   // the analog model adds one edge, the result register another
   task automatic cfg(input logic [31:0] d, input logic [31:0] exp, input logic [31:0] m);
      apb(1'h1, CC_ADDR, d);
      repeat (4) @(posedge clk);
      rd(CC_ADDR, exp, m);
   endtask

   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   initial begin
      {resetn, psel, penable, pwrite, idle, paddr, pwdata} = '0;
      vp = 8'h64;
      vm = 8'h28;
      repeat (20) @(posedge clk);
      resetn <= 1'h1;
      @(posedge clk);
      rd(CC_ADDR, 32'h0, '1);
      rd(RC_ADDR, 32'h0, '1);
      rd(4'h2, 32'h0, '1);
      chk(32'(err), 32'h1);
      apb(1'h1, 4'h2, 32'hFFFF_FFFF);
      chk(32'(err), 32'h1);
      rd(RC_ADDR, 32'h0, '1);
      apb(1'h1, IMASK_ADDR, 32'h1);
      apb(1'h1, RC_ADDR, 32'hDF);
      chk({24'h0, r_pwr, r_pin, r_rng, r_src, r_lvl}, 32'hDF);
      cfg(32'h0401, 32'h1441, '1);
      chk(32'(irq), 32'h1);
      cfg(32'h1511, 32'h1511, '1);
      chk(32'({a_oe, a_out}), 32'h2);
      rd(IST_ADDR, 32'h1, '1);
      chk(32'(irq), 32'h0);
      cfg(32'h0511, 32'h0511, '1);
      vp <= 8'h14;
      cfg(32'h0511, 32'h0551, 32'hCFFF);
      chk(32'({a_oe, a_out}), 32'h3);
      cfg(32'h0402, 32'h0442, 32'hCFFF);
      cfg(32'h0400, 32'h0400, 32'hCFFF);
      apb(1'h1, RC_ADDR, 32'hFF);
      cfg(32'h0402, 32'h0402, 32'hCFFF);
      cfg(32'h0000, 32'h0000, 32'hCFFF);
      chk(32'({a_on, a_oe}), 32'h0);
      vp <= 8'h64;
      rd(IST_ADDR, 32'h1, '1);
      cfg(32'h0A04, 32'h0A84, 32'hCFFF);
      chk(32'({b_on, b_oe, b_out}), 32'h7);
      cfg(32'h0A24, 32'h0A24, 32'hCFFF);
      chk(32'(irq), 32'h0);
      apb(1'h1, IMASK_ADDR, 32'h2);
      rd(IMASK_ADDR, 32'h2, '1);
      chk(32'(irq), 32'h1);
      cfg(32'h8A24, 32'h8A24, 32'hCFFF);
      idle <= 1'h1;
      @(posedge clk);
      chk(32'(irq), 32'h0);
      idle <= 1'h0;
      @(posedge clk);
      chk(32'(irq), 32'h1);
      rd(IST_ADDR, 32'h2, '1);
      chk(32'(irq), 32'h0);
      summarize();
   end
endmodule
